/* File: verilog/ser_map.vh */
// Purpose: constants for the status and event reporting block
// Assumes: one 20 MHz clock, commands decoded outside this block
// Notes:   bit positions follow the summary byte and event latch layout
`ifndef SER_MAP_VH
`define SER_MAP_VH
// ----------------------------------------
// Summary byte bit positions
// ----------------------------------------
`define SER_SUM_EQ      2
`define SER_SUM_QUES    3
`define SER_SUM_MAV     4
`define SER_SUM_EVT     5
`define SER_SUM_MASTER  6
`define SER_SUM_OPER    7
// ----------------------------------------
// Event latch bit positions
// ----------------------------------------
`define SER_EV_DONE     0
`define SER_EV_QRY      2
`define SER_EV_DDE      3
`define SER_EV_EXE      4
`define SER_EV_CME      5
`define SER_EV_PON      7
// ----------------------------------------
// Operation register
// ----------------------------------------
// No operation bit has a function, so none may show or latch
`define SER_OPER_USED   16'h0000
// ----------------------------------------
// Error codes pushed to the error queue
// ----------------------------------------
`define SER_ERR_DDE     16'hF_ED4
`define SER_ERR_EXE     16'hF_F38
`define SER_ERR_CME     16'hF_F9C
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SER_RST_BYTE    8'h0_0
`define SER_RST_WORD    16'h0_000
`endif

/* File: verilog/ser_latch.v */
// Purpose: generic latched event register with enable and sum bit
// Assumes: set and read-clear are one-cycle pulses
// Notes:   a set in the clearing cycle survives the clear
`timescale 1ns/1ps
`include "ser_map.vh"
module ser_latch
#(
   parameter WIDTH = 8
)
(
   // Clock and reset
   input  wire             mclk,
   input  wire             rst,
   // Events
   input  wire [WIDTH-1:0] set_in,
   input  wire             rd_clr,
   // Enable and result
   input  wire [WIDTH-1:0] enable,
   output reg  [WIDTH-1:0] latch_r,
   output wire             sum_bit
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         always @(posedge mclk or posedge rst)
         begin
            if (rst)
               latch_r[i] <= 1'b0;
            else if (set_in[i])
               latch_r[i] <= 1'b1;
            else if (rd_clr)
               latch_r[i] <= 1'b0;
         end
      end
   endgenerate
   assign sum_bit = |(latch_r & enable);
endmodule

/* File: verilog/ser_top.v */
// Purpose: status byte, event latch and operation register of the unit
// Assumes: command decoder drives one-cycle strobes synchronous to mclk
// Notes:   all outputs are registered
`timescale 1ns/1ps
`include "ser_map.vh"
module ser_top
#(
   parameter OPW = 16
)
(
   // Clock and reset
   input  wire           mclk,
   input  wire           rst,
   // Lower summary inputs from outside
   input  wire           err_queue_nonempty,
   input  wire           ques_sum,
   input  wire           msg_avail,
   // Command strobes
   input  wire           completion_marker_cmd,
   input  wire           cmds_pending,
   input  wire           read_without_query,
   input  wire           response_unfetched,
   input  wire           device_fault,
   input  wire           exec_fail,
   input  wire           cmd_bad,
   // Mask writes
   input  wire           evmask_wr,
   input  wire [7:0]     evmask_wdata,
   input  wire           reqmask_wr,
   input  wire [7:0]     reqmask_wdata,
   input  wire           oper_en_wr,
   input  wire [OPW-1:0] oper_en_wdata,
   // Reads
   input  wire           evlatch_rd,
   input  wire           oper_rd,
   // Operation activity
   input  wire [OPW-1:0] oper_live,
   // Outputs
   output reg  [7:0]     status_summary_byte,
   output reg  [7:0]     event_status_rdata,
   output reg  [7:0]     event_enable_mask,
   output reg  [7:0]     request_enable_mask,
   output reg  [OPW-1:0] operation_status_cond,
   output reg  [OPW-1:0] operation_status_event,
   output reg  [OPW-1:0] operation_enable_mask,
   output reg            service_request,
   output reg            err_push,
   output reg  [15:0]    err_code
);
   // ----------------------------------------
   // Completion marker wait
   // ----------------------------------------
   reg        done_wait_r;
   reg        pon_r;
   wire       done_set;
   assign done_set = (done_wait_r | completion_marker_cmd) & ~cmds_pending;
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         done_wait_r <= 1'b0;
      else if (done_set)
         done_wait_r <= 1'b0;
      else if (completion_marker_cmd)
         done_wait_r <= 1'b1;
   end
   // Power-on flag raised once after reset release
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         pon_r <= 1'b1;
      else
         pon_r <= 1'b0;
   end
   // ----------------------------------------
   // Event latch
   // ----------------------------------------
   wire [7:0] ev_set;
   wire [7:0] ev_q;
   wire       ev_sum;
   assign ev_set[`SER_EV_DONE] = done_set;
   assign ev_set[1]            = 1'b0;
   assign ev_set[`SER_EV_QRY]  = read_without_query
                               | response_unfetched;
   assign ev_set[`SER_EV_DDE]  = device_fault;
   assign ev_set[`SER_EV_EXE]  = exec_fail;
   assign ev_set[`SER_EV_CME]  = cmd_bad;
   assign ev_set[6]            = 1'b0;
   assign ev_set[`SER_EV_PON]  = pon_r;
   ser_latch #(.WIDTH(8)) u_evlatch
   (
      .mclk    (mclk),
      .rst     (rst),
      .set_in  (ev_set),
      .rd_clr  (evlatch_rd),
      .enable  (event_enable_mask),
      .latch_r (ev_q),
      .sum_bit (ev_sum)
   );
   // ----------------------------------------
   // Operation register
   // ----------------------------------------
   // No function is defined, so only the used mask bits can ever latch
   wire [OPW-1:0] op_set;
   wire [OPW-1:0] op_q;
   wire           op_sum;
   reg  [OPW-1:0] op_prev_r;
   assign op_set = op_prev_r & ~oper_live & `SER_OPER_USED;
   ser_latch #(.WIDTH(OPW)) u_oper
   (
      .mclk    (mclk),
      .rst     (rst),
      .set_in  (op_set),
      .rd_clr  (oper_rd),
      .enable  (operation_enable_mask),
      .latch_r (op_q),
      .sum_bit (op_sum)
   );
   // ----------------------------------------
   // Summary byte
   // ----------------------------------------
   reg  [7:0] sum_nxt;
   reg  [7:0] sum_prev_r;
   wire       master_sum;
   always @*
   begin
      sum_nxt                 = `SER_RST_BYTE;
      sum_nxt[`SER_SUM_EQ]    = err_queue_nonempty;
      sum_nxt[`SER_SUM_QUES]  = ques_sum;
      sum_nxt[`SER_SUM_MAV]   = msg_avail;
      sum_nxt[`SER_SUM_EVT]   = ev_sum;
      sum_nxt[`SER_SUM_OPER]  = op_sum;
   end
   // Mask bit 6 ignored, the master bit is never its own source
   assign master_sum = |(sum_nxt & request_enable_mask
                         & ~(8'h4_0));
   // ----------------------------------------
   // Registers and outputs
   // ----------------------------------------
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         status_summary_byte    <= `SER_RST_BYTE;
         sum_prev_r             <= `SER_RST_BYTE;
         event_status_rdata     <= `SER_RST_BYTE;
         event_enable_mask      <= `SER_RST_BYTE;
         request_enable_mask    <= `SER_RST_BYTE;
         operation_status_cond  <= `SER_RST_WORD;
         operation_status_event <= `SER_RST_WORD;
         operation_enable_mask  <= `SER_RST_WORD;
         op_prev_r              <= `SER_RST_WORD;
         service_request        <= 1'b0;
         err_push               <= 1'b0;
         err_code               <= `SER_RST_WORD;
      end
      else
      begin
         status_summary_byte    <= sum_nxt
                                 | {1'b0, master_sum, 6'h0_0};
         sum_prev_r             <= sum_nxt & request_enable_mask;
         event_status_rdata     <= ev_q;
         if (evmask_wr)
            event_enable_mask   <= evmask_wdata;
         if (reqmask_wr)
            request_enable_mask <= reqmask_wdata;
         if (oper_en_wr)
            operation_enable_mask <= oper_en_wdata;
         op_prev_r              <= oper_live & `SER_OPER_USED;
         operation_status_cond  <= oper_live & `SER_OPER_USED;
         operation_status_event <= op_q & `SER_OPER_USED;
         service_request <= |(sum_nxt & request_enable_mask
                              & ~sum_prev_r & ~(8'h4_0));
         err_push <= device_fault | exec_fail | cmd_bad;
         if (device_fault)
            err_code <= `SER_ERR_DDE;
         else if (exec_fail)
            err_code <= `SER_ERR_EXE;
         else if (cmd_bad)
            err_code <= `SER_ERR_CME;
      end
   end
endmodule

/* File: bench/ser_monitor.sv */
// Purpose: assertions on the status reporting block ports
// Assumes: decoded strobes are one-cycle pulses
// Notes:   bound to ser_top
`timescale 1ns/1ps
module ser_monitor
#(
   parameter OPW = 16
)
(
   // Watched ports
   input wire           mclk,
   input wire           rst,
   input wire           cmd_bad,
   input wire           exec_fail,
   input wire           read_without_query,
   input wire           completion_marker_cmd,
   input wire           cmds_pending,
   input wire [7:0]     status_summary_byte,
   input wire [7:0]     event_status_rdata,
   input wire [7:0]     event_enable_mask,
   input wire [7:0]     request_enable_mask,
   input wire [OPW-1:0] operation_status_cond,
   input wire           service_request
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   chk_cmd_flag: assert property (cmd_bad |-> ##[1:3]
      event_status_rdata[5]) else $error("command flag missing");
   chk_exec_flag: assert property (exec_fail |-> ##[1:3]
      event_status_rdata[4]) else $error("execution flag missing");
   chk_query_flag: assert property (read_without_query |-> ##[1:3]
      event_status_rdata[2]) else $error("query flag missing");
   chk_done_flag: assert property (completion_marker_cmd &&
      !cmds_pending |-> ##[1:3] event_status_rdata[0])
      else $error("completion flag missing");
   chk_power_flag: assert property ($fell(rst) |-> ##[0:3]
      event_status_rdata[7]) else $error("power-on flag missing");
   chk_oper_zero: assert property (!operation_status_cond[15] &&
      !status_summary_byte[7]) else $error("operation bit set");
   chk_event_sum: assert property ($stable(event_enable_mask) &&
      $stable(event_status_rdata) |-> status_summary_byte[5] ==
      |(event_status_rdata & event_enable_mask))
      else $error("event summary wrong");
   chk_srq_edge: assert property ($rose(status_summary_byte[5]) &&
      request_enable_mask[5] |-> ##[0:2] service_request)
      else $error("service request missing");
endmodule

bind ser_top ser_monitor #(.OPW(OPW)) i_ser_monitor (.mclk(mclk),
   .rst(rst), .cmd_bad(cmd_bad), .exec_fail(exec_fail),
   .read_without_query(read_without_query),
   .completion_marker_cmd(completion_marker_cmd),
   .cmds_pending(cmds_pending), .status_summary_byte(status_summary_byte),
   .event_status_rdata(event_status_rdata),
   .event_enable_mask(event_enable_mask),
   .request_enable_mask(request_enable_mask),
   .operation_status_cond(operation_status_cond),
   .service_request(service_request));

/* File: bench/ser_ctrl_model.sv */
// Purpose: remote controller model sending decoded strobes
// Assumes: strobes change at the falling edge of mclk
// Notes:   data is inverted once released, so stale data is never reused
`timescale 1ns/1ps
module ser_ctrl_model
(
   // Clock
   input wire        mclk,
   // Strobes and data
   output reg  [5:0] ev,
   output reg        lat_rd,
   output reg        evm_wr,
   output reg        rqm_wr,
   output reg  [7:0] wdata
);
   initial {ev, lat_rd, evm_wr, rqm_wr, wdata} = '0;
   task pulse(input [5:0] e, input r, input we, input ws, input [7:0] d);
   begin
      @(negedge mclk);
      {ev, lat_rd, evm_wr, rqm_wr, wdata} = {e, r, we, ws, d};
      @(negedge mclk);
      {ev, lat_rd, evm_wr, rqm_wr, wdata} = {9'h000, ~d};
   end
   endtask
endmodule

/* File: bench/ser_top_tb.sv */
// Purpose: directed bench for the status reporting block
// Assumes: inputs change on the falling edge of mclk
// Notes:   controller strobes come from the partner model
`timescale 1ns/1ps
module ser_top_tb;
   reg         mclk;
   reg         rst;
   reg  [2:0]  lvl;
   reg         pend;
   reg  [15:0] oplive;
   wire [5:0]  ev;
   wire        lat_rd, evm_wr, rqm_wr, srq, epush;
   wire [7:0]  wdata, sb, rd, evm, rqm;
   wire [15:0] cond, opev, opmask, ecode;
   integer     fails, tests_run, i;
   ser_ctrl_model i_ser_ctrl_model (.mclk(mclk), .ev(ev), .lat_rd(lat_rd),
      .evm_wr(evm_wr), .rqm_wr(rqm_wr), .wdata(wdata));
   ser_top #(.OPW(16)) i_ser_top (.mclk(mclk), .rst(rst),
      .err_queue_nonempty(lvl[2]), .ques_sum(lvl[1]), .msg_avail(lvl[0]),
      .completion_marker_cmd(ev[0]), .cmds_pending(pend),
      .read_without_query(ev[1]), .response_unfetched(ev[2]),
      .device_fault(ev[3]), .exec_fail(ev[4]), .cmd_bad(ev[5]),
      .evmask_wr(evm_wr), .evmask_wdata(wdata), .reqmask_wr(rqm_wr),
      .reqmask_wdata(wdata), .oper_en_wr(1'b1), .oper_en_wdata(16'hFFFF),
      .evlatch_rd(lat_rd), .oper_rd(1'b0), .oper_live(oplive),
      .status_summary_byte(sb), .event_status_rdata(rd),
      .event_enable_mask(evm), .request_enable_mask(rqm),
      .operation_status_cond(cond), .operation_status_event(opev),
      .operation_enable_mask(opmask), .service_request(srq),
      .err_push(epush), .err_code(ecode));
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task chk(input [15:0] got, input [15:0] exp);
   begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   end
   endtask
   task end_sim;
   begin
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   task p(input [5:0] e, input r, input we, input ws, input [7:0] d);
   begin
      i_ser_ctrl_model.pulse(e, r, we, ws, d);
      repeat (2) @(negedge mclk);
   end
   endtask
   task t_events;
   begin
      chk(rd, 16'h0080);
      p(6'h00, 1'b1, 1'b0, 1'b0, 8'h00);
      chk(rd, 16'h0000);
      for (i = 1; i < 6; i = i + 1)
      begin
         i_ser_ctrl_model.pulse(6'h01 << i, 1'b0, 1'b0, 1'b0, 8'h00);
         chk(epush, (i > 2) ? 16'h0001 : 16'h0000);
         if (i > 2)
            chk(ecode, (i == 3) ? 16'hFED4 :
               (i == 4) ? 16'hFF38 : 16'hFF9C);
         repeat (2) @(negedge mclk);
         chk(rd, 16'h0001 << ((i < 3) ? 2 : i));
         p(6'h00, 1'b1, 1'b0, 1'b0, 8'h00);
      end
   end
   endtask
   task t_done;
   begin
      pend = 1'b1;
      p(6'h01, 1'b0, 1'b0, 1'b0, 8'h00);
      chk(rd, 16'h0000);
      pend = 1'b0;
      repeat (3) @(negedge mclk);
      chk(rd, 16'h0001);
      p(6'h00, 1'b1, 1'b0, 1'b0, 8'h00);
   end
   endtask
   task t_srq;
   begin
      p(6'h00, 1'b0, 1'b1, 1'b0, 8'h20);
      chk(evm, 16'h0020);
      p(6'h00, 1'b0, 1'b0, 1'b1, 8'h60);
      chk(rqm, 16'h0060);
      i_ser_ctrl_model.pulse(6'h20, 1'b0, 1'b0, 1'b0, 8'h00);
      i = 0;
      while (srq !== 1'b1 && i < 8)
      begin
         @(negedge mclk);
         i = i + 1;
      end
      chk(srq, 16'h0001);
      repeat (2) @(negedge mclk);
      chk(sb & 8'h60, 16'h0060);
      p(6'h00, 1'b0, 1'b0, 1'b1, 8'h40);
      chk(sb & 8'h60, 16'h0020);
      p(6'h00, 1'b1, 1'b0, 1'b0, 8'h00);
      chk(sb, 16'h0000);
   end
   endtask
   task t_levels;
   begin
      lvl = 3'b111;
      oplive = 16'hFFFF;
      repeat (3) @(negedge mclk);
      chk(cond, 16'h0000);
      oplive = 16'h0000;
      repeat (3) @(negedge mclk);
      chk(opev, 16'h0000);
      chk(opmask, 16'hFFFF);
      chk(sb, 16'h001C);
      chk(cond[15], 16'h0000);
   end
   endtask
   initial
   begin
      #200000;
      fails = fails + 1;
      end_sim;
   end
   initial
   begin
      fails = 0;
      tests_run = 0;
      rst = 1'b1;
      lvl = 3'b000;
      pend = 1'b0;
      oplive = 16'h0000;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      repeat (3) @(negedge mclk);
      t_events;
      t_done;
      t_srq;
      t_levels;
      end_sim;
   end
endmodule
